// [core/sbac_slot_bus.sv]
// Purpose : slot address bus direction, local access claim and chip-select outputs
// Assumes : pins from other domains pass a two-flop synchroniser first
// Notes   : control bits arrive as plain ports; no register bus
`timescale 1ns/1ps
module sbac_slot_bus
  import sbac_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  input  wire logic                         power_on_reset,
  // ownership and cycle
  input  wire logic                         hold_ack,
  input  wire logic                         master_active,
  input  wire logic                         refresh_active,
  input  wire sbac_cycle_req_type           req,
  input  wire logic                         cycle_end,
  input  wire logic [8:0]                   refresh_row,
  input  wire logic                         local_region_hit,
  // control bits
  input  wire logic [7:0]                   bus_control_reg,
  input  wire logic [7:0]                   rtc_low_byte_reg,
  input  wire logic                         internal_keyboard_ctrl,
  input  wire logic [SBAC_SHADOW_BITS-1:0]  shadow_enable,
  // pins
  input  wire logic                         local_access_claim_n,
  input  wire logic                         ready_n_i,
  input  wire logic                         own_ready_n,
  input  wire logic                         strap_pin_i,
  input  wire logic [6:0]                   la_i,
  input  wire logic [7:0]                   sa_mid_i,
  input  wire logic [8:0]                   sa_low_i,
  output sbac_addr_pins_type                addr_pins,
  output logic                              local_addr_strobe_n,
  output logic                              local_addr_strobe_oe,
  output logic                              write_read_select,
  output logic                              write_read_select_oe,
  output logic                              ready_n_o,
  output logic                              ready_n_oe,
  output logic                              boot_rom_select_n,
  output logic                              peripheral_select_n,
  output logic                              select_pin_oe,
  output logic                              config_strap,
  output logic                              claim_active,
  output logic                              claim_ready_seen,
  output logic [23:0]                       master_addr
);

  // ==========================================================
  // synchronisers
  logic       claim_meta;
  logic       claim_sync;
  logic       ready_meta;
  logic       ready_sync;
  logic       strap_meta;
  logic       strap_sync;
  logic [6:0] la_meta;
  logic [6:0] la_sync;
  logic [7:0] mid_meta;
  logic [7:0] mid_sync;
  logic [8:0] low_meta;
  logic [8:0] low_sync;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      claim_meta <= 1'b1;
      claim_sync <= 1'b1;
      ready_meta <= 1'b1;
      ready_sync <= 1'b1;
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      la_meta    <= 7'h00;
      la_sync    <= 7'h00;
      mid_meta   <= 8'h00;
      mid_sync   <= 8'h00;
      low_meta   <= 9'h000;
      low_sync   <= 9'h000;
    end else begin
      claim_meta <= local_access_claim_n;
      claim_sync <= claim_meta;
      ready_meta <= ready_n_i;
      ready_sync <= ready_meta;
      strap_meta <= strap_pin_i;
      strap_sync <= strap_meta;
      la_meta    <= la_i;
      la_sync    <= la_meta;
      mid_meta   <= sa_mid_i;
      mid_sync   <= mid_meta;
      low_meta   <= sa_low_i;
      low_sync   <= low_meta;
    end
  end

  // ==========================================================
  // ownership
  sbac_owner_type owner;

  always_comb begin
    if (refresh_active) begin
      owner = SBAC_OWN_REFRESH;
    end else if (hold_ack && master_active) begin
      owner = SBAC_OWN_MASTER;
    end else if (hold_ack) begin
      owner = SBAC_OWN_DMA;
    end else begin
      owner = SBAC_OWN_CPU;
    end
  end

  // slot_addr_enable: hold granted to the dma engine, not to a master
  logic slot_addr_enable;
  assign slot_addr_enable = hold_ack && !master_active;

  // ==========================================================
  // address pin drive
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_pins <= '0;
    end else begin
      unique case (owner)
        SBAC_OWN_CPU, SBAC_OWN_DMA: begin
          addr_pins.la_o      <= req.addr[23:17];
          addr_pins.la_oe     <= 7'h7f;
          addr_pins.sa_high_o <= req.addr[19:17];
          addr_pins.sa_mid_o  <= req.addr[16:9];
          addr_pins.sa_mid_oe <= 8'hff;
          addr_pins.sa_low_o  <= req.addr[8:0];
          addr_pins.sa_low_oe <= 9'h1ff;
        end
        SBAC_OWN_MASTER: begin
          addr_pins.la_o      <= 7'h00;
          addr_pins.la_oe     <= 7'h00;
          // top slot bits are always driven; copy the master's latchable bits
          addr_pins.sa_high_o <= la_sync[2:0];
          addr_pins.sa_mid_o  <= 8'h00;
          addr_pins.sa_mid_oe <= 8'h00;
          addr_pins.sa_low_o  <= 9'h000;
          addr_pins.sa_low_oe <= 9'h000;
        end
        SBAC_OWN_REFRESH: begin
          addr_pins.la_o      <= 7'h00;
          addr_pins.la_oe     <= 7'h7f;
          addr_pins.sa_high_o <= 3'h0;
          addr_pins.sa_mid_o  <= 8'h00;
          addr_pins.sa_mid_oe <= 8'h00;
          addr_pins.sa_low_o  <= refresh_row;
          addr_pins.sa_low_oe <= 9'h1ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      master_addr <= 24'h000000;
    end else if (owner == SBAC_OWN_MASTER) begin
      master_addr <= {la_sync, mid_sync, low_sync};
    end
  end

  // ==========================================================
  // local access claim
  logic claim_window;
  logic claim_take;
  logic local_access_enable;
  assign local_access_enable = bus_control_reg[SBAC_LOCAL_ACCESS_EN_BIT];
  // the claim is only looked at in the first clock of a cpu cycle (synced sample)
  assign claim_window = req.start && !hold_ack;
  assign claim_take   = claim_window && local_access_enable && !claim_sync;

  // a new claim wins over a cycle end falling in the same clock
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      claim_active <= 1'b0;
    end else if (claim_take) begin
      claim_active <= 1'b1;
    end else if (cycle_end) begin
      claim_active <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      claim_ready_seen <= 1'b0;
    end else if (claim_active && !ready_sync) begin
      claim_ready_seen <= 1'b1;
    end else if (cycle_end) begin
      claim_ready_seen <= 1'b0;
    end
  end

  // ready drive: own completion only when no claim and not in hold
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_n_o  <= 1'b1;
      ready_n_oe <= 1'b0;
    end else begin
      ready_n_o  <= own_ready_n;
      // claim_take keeps own ready off from the very edge the claim is taken
      ready_n_oe <= !claim_active && !claim_take && !hold_ack && !own_ready_n;
    end
  end

  // ==========================================================
  // local strobe during dma and master cycles
  logic wr_cycle;
  assign wr_cycle = (req.kind == SBAC_CYC_MEM_WR) || (req.kind == SBAC_CYC_IO_WR);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      local_addr_strobe_n  <= 1'b1;
      local_addr_strobe_oe <= 1'b0;
      write_read_select    <= 1'b0;
      write_read_select_oe <= 1'b0;
    end else begin
      local_addr_strobe_n  <= !(hold_ack && local_region_hit && req.start);
      local_addr_strobe_oe <= hold_ack && !refresh_active;
      if (hold_ack && local_region_hit && req.active) begin
        write_read_select    <= wr_cycle;
        write_read_select_oe <= 1'b1;
      end else begin
        write_read_select_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // chip selects and strap
  logic rom_hit;
  logic ppi_hit;

  sbac_select_decode u_decode (
    .req                    (req),
    .hold_ack               (hold_ack),
    .slot_addr_enable       (slot_addr_enable),
    .internal_keyboard_ctrl (internal_keyboard_ctrl),
    .shadow_enable          (shadow_enable),
    .rom_hit                (rom_hit),
    .ppi_hit                (ppi_hit)
  );

  logic rtc_enable_unused;
  assign rtc_enable_unused = rtc_low_byte_reg[SBAC_RTC_ENABLE_BIT];

  // strap is caught while power-on reset is held, pin is an input then
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      config_strap  <= 1'b0;
      select_pin_oe <= 1'b0;
    end else if (power_on_reset) begin
      config_strap  <= strap_sync;
      select_pin_oe <= 1'b0;
    end else begin
      select_pin_oe <= 1'b1;
    end
  end

  // selects latch at cycle start and stand until the cycle ends, the rom select only until hold is granted
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      boot_rom_select_n   <= 1'b1;
      peripheral_select_n <= 1'b1;
    end else if (cycle_end || !req.active) begin
      boot_rom_select_n   <= 1'b1;
      peripheral_select_n <= 1'b1;
    end else if (hold_ack && !req.start) begin
      // the cpu has given the bus away: a rom select left from its cycle must drop
      boot_rom_select_n   <= 1'b1;
    end else if (req.start) begin
      boot_rom_select_n   <= !rom_hit;
      peripheral_select_n <= !ppi_hit;
    end
  end

  // ==========================================================
  // checks
  rom_cpu_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    hold_ack |=> boot_rom_select_n)
    else $error("rom select active in hold");
  ppi_no_dma_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.start && slot_addr_enable && req.active) |=> peripheral_select_n)
    else $error("peripheral select during dma hold");
  ppi_io_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (req.start && req.active && (req.kind inside {SBAC_CYC_MEM_RD, SBAC_CYC_MEM_WR}))
      |=> peripheral_select_n)
    else $error("peripheral select on memory cycle");
  refresh_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    refresh_active |=> addr_pins.sa_high_o == 3'h0 && addr_pins.la_o == 7'h00)
    else $error("refresh address not low");
  refresh_mid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    refresh_active |=> addr_pins.sa_mid_oe == 8'h00 && addr_pins.sa_low_o == $past(refresh_row))
    else $error("refresh mid not floated or row wrong");
  master_input_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hold_ack && master_active && !refresh_active)
      |=> addr_pins.la_oe == 7'h00 && addr_pins.sa_low_oe == 9'h000)
    else $error("address driven during master");
  claim_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!bus_control_reg[SBAC_LOCAL_ACCESS_EN_BIT] && !claim_active) |=> !$rose(claim_active))
    else $error("claim taken while disabled");
  claim_ready_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    claim_active |=> !ready_n_oe)
    else $error("ready driven during claim");
  strobe_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !local_addr_strobe_n |=> local_addr_strobe_n)
    else $error("strobe longer than one clock");
  strap_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    power_on_reset |=> !select_pin_oe)
    else $error("select pin driven during strap sampling");

endmodule : sbac_slot_bus

// [core/sbac_pkg.sv]
// Purpose : shared constants and carriers for the slot bus address and chip-select block
// Assumes : one 50 MHz clock, synchronous active-low reset
package sbac_pkg;

  // ==========================================================
  // address decode
  localparam logic [23:0] SBAC_TOP_ROM_BASE  = 24'hfe0000;
  localparam logic [23:0] SBAC_LOW_ROM_BASE  = 24'h0e0000;
  localparam logic [23:0] SBAC_LOW_ROM_LAST  = 24'h0fffff;
  localparam logic [15:0] SBAC_PORT_KBD_DATA = 16'h0060;
  localparam logic [15:0] SBAC_PORT_KBD_CMD  = 16'h0064;
  localparam logic [15:0] SBAC_PORT_RTC_IDX  = 16'h0070;
  localparam logic [15:0] SBAC_PORT_RTC_DATA = 16'h0071;
  // shadow granularity: eight 16 KB pieces of 0e0000-0fffff
  localparam int          SBAC_SHADOW_BITS   = 8;
  localparam int          SBAC_SHADOW_LSB    = 14;
  localparam int          SBAC_LOCAL_ACCESS_EN_BIT = 4;
  localparam int          SBAC_RTC_ENABLE_BIT      = 0;

  // ==========================================================
  // bus ownership and cycle types
  typedef enum logic [1:0] {
    SBAC_OWN_CPU,
    SBAC_OWN_DMA,
    SBAC_OWN_MASTER,
    SBAC_OWN_REFRESH
  } sbac_owner_type;

  typedef enum logic [1:0] {
    SBAC_CYC_MEM_RD,
    SBAC_CYC_MEM_WR,
    SBAC_CYC_IO_RD,
    SBAC_CYC_IO_WR
  } sbac_cycle_type;

  // one bus cycle request from the cpu or the internal dma/master logic
  typedef struct packed {
    logic           start;
    logic           active;
    sbac_cycle_type kind;
    logic [23:0]    addr;
  } sbac_cycle_req_type;

  // output and enable view of the bidirectional address pin groups
  typedef struct packed {
    logic [6:0] la_o;
    logic [6:0] la_oe;
    logic [2:0] sa_high_o;
    logic [7:0] sa_mid_o;
    logic [7:0] sa_mid_oe;
    logic [8:0] sa_low_o;
    logic [8:0] sa_low_oe;
  } sbac_addr_pins_type;

endpackage : sbac_pkg

// [core/sbac_select_decode.sv]
// Purpose : combinational decode of boot rom and peripheral selects
// Assumes : address and cycle type held stable by caller for the cycle
// Notes   : pure function of inputs, registered in the parent
`timescale 1ns/1ps
module sbac_select_decode
  import sbac_pkg::*;
(
  input  wire sbac_cycle_req_type           req,
  input  wire logic                         hold_ack,
  input  wire logic                         slot_addr_enable,
  input  wire logic                         internal_keyboard_ctrl,
  input  wire logic [SBAC_SHADOW_BITS-1:0]  shadow_enable,
  output logic                              rom_hit,
  output logic                              ppi_hit
);

  logic       is_mem;
  logic       is_io;
  logic       in_low_rom;
  logic       shadowed;
  logic [2:0] piece;
  logic [15:0] port;

  always_comb begin
    is_mem     = (req.kind == SBAC_CYC_MEM_RD) || (req.kind == SBAC_CYC_MEM_WR);
    is_io      = (req.kind == SBAC_CYC_IO_RD) || (req.kind == SBAC_CYC_IO_WR);
    in_low_rom = (req.addr >= SBAC_LOW_ROM_BASE) && (req.addr <= SBAC_LOW_ROM_LAST);
    piece      = req.addr[SBAC_SHADOW_LSB +: 3];
    // shadow only covers the low copy; the top alias always reaches the rom
    shadowed   = in_low_rom && shadow_enable[piece];
    port       = req.addr[15:0];
    rom_hit    = req.active && !hold_ack && is_mem
                 && ((req.addr >= SBAC_TOP_ROM_BASE) || in_low_rom) && !shadowed;
    ppi_hit    = req.active && is_io && !slot_addr_enable
                 && ((port == SBAC_PORT_RTC_IDX) || (port == SBAC_PORT_RTC_DATA)
                     || (!internal_keyboard_ctrl
                         && ((port == SBAC_PORT_KBD_DATA) || (port == SBAC_PORT_KBD_CMD))));
  end

endmodule : sbac_select_decode

// [verif/sbac_far_end.sv]
// Purpose : far-side model: a local peripheral that claims cycles and ends them with ready
// Assumes : the peripheral raises its claim well ahead of the cycle it wants
// Notes   : the ready wire and the strap pin carry external resistors
`timescale 1ns/1ps
module sbac_far_end
  import sbac_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       want_claim,
  input  wire logic [3:0] ready_delay,
  input  wire logic       ready_n_o,
  input  wire logic       ready_n_oe,
  input  wire logic       pin_o,
  input  wire logic       select_pin_oe,
  input  wire logic       strap_level,
  output logic            local_access_claim_n,
  output logic            ready_n_i,
  output logic            strap_pin_i
);
  logic [3:0] wait_cnt;
  logic       drive_ready = 1'b0;

  // ==========================================================
  // claim and ready
  // claim goes low long before the cycle starts, so it lands ahead of the first T2 mid-point
  assign local_access_claim_n = ~want_claim;
  always_ff @(posedge clk_sys) begin
    if (!want_claim) begin
      wait_cnt    <= 4'h0;
      drive_ready <= 1'b0;
    end else begin
      wait_cnt    <= wait_cnt + 4'h1;
      drive_ready <= (wait_cnt == ready_delay);
    end
  end
  // pull-up holds the wire high when nobody drives it
  assign ready_n_i   = ready_n_oe ? ready_n_o : ~drive_ready;
  assign strap_pin_i = select_pin_oe ? pin_o : strap_level;
endmodule : sbac_far_end

// [verif/tb.sv]
// Purpose : self-checking bench for the slot bus address and chip-select block
// Assumes : 50 MHz clk_sys, synchronous active-low reset
// Notes   : bench plays cpu, dma, refresh and slot master; far end model plays the peripheral
`timescale 1ns/1ps
module tb
  import sbac_pkg::*;
();
  localparam sbac_cycle_type mr = SBAC_CYC_MEM_RD;
  localparam sbac_cycle_type mw = SBAC_CYC_MEM_WR;
  localparam sbac_cycle_type ir = SBAC_CYC_IO_RD;
  localparam sbac_cycle_type iw = SBAC_CYC_IO_WR;
  logic                        clk_sys = 1'b0;
  logic                        resetn, power_on_reset, hold_ack, master_active, refresh_active;
  sbac_cycle_req_type          req;
  logic                        cycle_end, local_region_hit, internal_keyboard_ctrl, own_ready_n;
  logic [7:0]                  bus_control_reg, rtc_low_byte_reg;
  logic [SBAC_SHADOW_BITS-1:0] shadow_enable;
  logic                        want_claim, strap_level, local_access_claim_n, ready_n_i, strap_pin_i;
  logic [6:0]                  la_i;
  logic [7:0]                  sa_mid_i;
  logic [8:0]                  sa_low_i;
  logic [8:0]                  refresh_row = 9'h15a;
  sbac_addr_pins_type          addr_pins;
  logic                        local_addr_strobe_n, local_addr_strobe_oe, write_read_select;
  logic                        write_read_select_oe, ready_n_o, ready_n_oe, boot_rom_select_n;
  logic                        peripheral_select_n, select_pin_oe, config_strap, claim_active, claim_ready_seen;
  logic [23:0]                 master_addr;
  logic [23:0]                 mst = 24'haa7a5;
  int                          failures = 0;
  int                          checks = 0;

  always #10 clk_sys = ~clk_sys;
  // slot master drives whatever the block has released
  assign la_i     = (addr_pins.la_o & addr_pins.la_oe) | (mst[23:17] & ~addr_pins.la_oe);
  assign sa_mid_i = (addr_pins.sa_mid_o & addr_pins.sa_mid_oe) | (mst[16:9] & ~addr_pins.sa_mid_oe);
  assign sa_low_i = (addr_pins.sa_low_o & addr_pins.sa_low_oe) | (mst[8:0] & ~addr_pins.sa_low_oe);

  sbac_slot_bus uut (.clk_sys, .resetn, .power_on_reset, .hold_ack, .master_active, .refresh_active,
    .req, .cycle_end, .refresh_row, .local_region_hit, .bus_control_reg, .rtc_low_byte_reg,
    .internal_keyboard_ctrl, .shadow_enable, .local_access_claim_n, .ready_n_i, .own_ready_n,
    .strap_pin_i, .la_i, .sa_mid_i, .sa_low_i, .addr_pins, .local_addr_strobe_n, .local_addr_strobe_oe,
    .write_read_select, .write_read_select_oe, .ready_n_o, .ready_n_oe, .boot_rom_select_n,
    .peripheral_select_n, .select_pin_oe, .config_strap, .claim_active, .claim_ready_seen, .master_addr);
  sbac_far_end far (.clk_sys, .want_claim, .ready_delay(4'h6), .ready_n_o, .ready_n_oe,
    .pin_o(boot_rom_select_n & peripheral_select_n), .select_pin_oe, .strap_level,
    .local_access_claim_n, .ready_n_i, .strap_pin_i);

  // ==========================================================
  // helpers
  task automatic chk_vec(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_vec
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic mode(input logic h, input logic m, input logic r);
    @(posedge clk_sys);
    hold_ack       <= h;
    master_active  <= m;
    refresh_active <= r;
    tick(6);
  endtask : mode
  task automatic start_cyc(input sbac_cycle_type k, input logic [23:0] a);
    @(posedge clk_sys);
    req <= '{start: 1'b1, active: 1'b1, kind: k, addr: a};
    @(posedge clk_sys);
    req.start <= 1'b0;
  endtask : start_cyc
  task automatic end_cyc;
    @(posedge clk_sys);
    cycle_end <= 1'b1;
    @(posedge clk_sys);
    cycle_end  <= 1'b0;
    req.active <= 1'b0;
    tick(2);
  endtask : end_cyc
  // exp holds {rom select, peripheral select}, both active low
  task automatic sel_case(input sbac_cycle_type k, input logic [23:0] a, input logic [1:0] exp);
    start_cyc(k, a);
    tick(1);
    chk_vec(24'({boot_rom_select_n, peripheral_select_n}), 24'(exp));
    tick(3);
    chk_vec(24'({boot_rom_select_n, peripheral_select_n}), 24'(exp));
    end_cyc;
    chk_vec(24'({boot_rom_select_n, peripheral_select_n}), 24'h3);
  endtask : sel_case

  // ==========================================================
  // scenarios
  task automatic t_dir;
    for (int i = 0; i < 4; i++) begin
      mode(i == 1 || i == 2, i == 2, i == 3);
      chk_vec(24'(addr_pins.la_oe), (i == 2) ? 24'h0 : 24'h7f);
      chk_vec(24'(addr_pins.sa_mid_oe), (i < 2) ? 24'hff : 24'h0);
      chk_vec(24'(addr_pins.sa_low_oe), (i == 2) ? 24'h0 : 24'h1ff);
      chk_vec(24'(local_addr_strobe_oe), 24'(i == 1 || i == 2));
    end
    chk_vec(24'({addr_pins.la_o, addr_pins.sa_high_o}), 24'h0);
    chk_vec(24'(addr_pins.sa_low_o), 24'h15a);
    @(posedge clk_sys);
    refresh_row <= 9'h0a5;
    tick(2);
    chk_vec(24'(addr_pins.sa_low_o), 24'h0a5);
    mode(1'b1, 1'b1, 1'b0);
    chk_vec(24'(addr_pins.sa_high_o), 24'(mst[19:17]));
    chk_vec(master_addr, mst);
    mode(1'b0, 1'b0, 1'b0);
    $display("test bus direction done");
  endtask : t_dir
  task automatic t_sel;
    sel_case(mr, 24'hfe0000, 2'h1);
    sel_case(mw, 24'hffffff, 2'h1);
    sel_case(mr, 24'hfdffff, 2'h3);
    sel_case(mw, 24'h0e0000, 2'h1);
    sel_case(mr, 24'h0fffff, 2'h1);
    sel_case(mr, 24'h0dffff, 2'h3);
    sel_case(mr, 24'h000070, 2'h3);
    sel_case(ir, 24'hfe0070, 2'h2);
    sel_case(iw, 24'h000071, 2'h2);
    sel_case(ir, 24'h000060, 2'h3);
    sel_case(iw, 24'h000064, 2'h3);
    @(posedge clk_sys);
    shadow_enable          <= 8'h02;
    internal_keyboard_ctrl <= 1'b0;
    rtc_low_byte_reg       <= 8'h01;
    sel_case(mr, 24'h0e4000, 2'h3);
    sel_case(mw, 24'h0e3fff, 2'h1);
    sel_case(ir, 24'h000060, 2'h2);
    sel_case(iw, 24'h000064, 2'h2);
    sel_case(ir, 24'h000061, 2'h3);
    sel_case(iw, 24'h000070, 2'h2);
    mode(1'b1, 1'b0, 1'b0);
    sel_case(mr, 24'hfe0000, 2'h3);
    sel_case(ir, 24'h000070, 2'h3);
    mode(1'b1, 1'b1, 1'b0);
    sel_case(iw, 24'h000071, 2'h2);
    sel_case(mr, 24'h0f0000, 2'h3);
    mode(1'b0, 1'b0, 1'b0);
    $display("test selects done");
  endtask : t_sel
  task automatic t_claim;
    logic seen;
    seen = 1'b0;
    for (int e = 0; e < 3; e++) begin
      mode(e == 2, 1'b0, 1'b0);
      @(posedge clk_sys);
      bus_control_reg <= (e == 0) ? 8'h00 : 8'h10;
      want_claim      <= 1'b1;
      tick(3);
      start_cyc(ir, 24'h000300);
      // own ready goes low only once the cycle runs, so a ready seen later came from the peripheral
      own_ready_n <= 1'b0;
      tick(1);
      chk_vec(24'(claim_active), 24'(e == 1));
      for (int j = 0; j < 8; j++) begin
        chk_vec(24'(ready_n_oe), 24'(e == 0));
        if (e == 0) chk_vec(24'(ready_n_o), 24'h0);
        if (e == 1) seen = seen | claim_ready_seen;
        tick(1);
      end
      end_cyc;
      chk_vec(24'(claim_active), 24'h0);
      @(posedge clk_sys);
      want_claim  <= 1'b0;
      own_ready_n <= 1'b1;
    end
    chk_vec(24'(seen), 24'h1);
    mode(1'b0, 1'b0, 1'b0);
    $display("test local claim done");
  endtask : t_claim
  task automatic strobe_case(input logic m, input logic hit, input sbac_cycle_type k);
    int         lows;
    logic [2:0] cap;
    lows = 0;
    cap  = 3'h0;
    mode(1'b1, m, 1'b0);
    @(posedge clk_sys);
    local_region_hit <= hit;
    start_cyc(k, 24'h0c8000);
    for (int j = 0; j < 5; j++) begin
      #1;
      if (local_addr_strobe_n === 1'b0) begin
        lows++;
        cap = {local_addr_strobe_oe, write_read_select_oe, write_read_select};
      end
      @(posedge clk_sys);
    end
    chk_vec(24'(lows), 24'(hit));
    if (hit) chk_vec(24'(cap), {21'h0, 2'h3, k == mw});
    end_cyc;
  endtask : strobe_case
  task automatic t_strap(input logic lvl);
    @(posedge clk_sys);
    power_on_reset <= 1'b1;
    strap_level    <= lvl;
    tick(4);
    chk_vec(24'(select_pin_oe), 24'h0);
    @(posedge clk_sys);
    power_on_reset <= 1'b0;
    tick(3);
    chk_vec(24'(config_strap), 24'(lvl));
    $display("test strap done");
  endtask : t_strap
  task automatic finish_test;
    $display("counts: checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  initial begin
    {resetn, power_on_reset, hold_ack, master_active, refresh_active, cycle_end} = 6'h0;
    {local_region_hit, want_claim, strap_level} = 3'h0;
    req                    = '0;
    bus_control_reg        = 8'h00;
    rtc_low_byte_reg       = 8'h00;
    shadow_enable          = 8'h00;
    internal_keyboard_ctrl = 1'b1;
    own_ready_n            = 1'b1;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    tick(1);
    chk_vec(24'({boot_rom_select_n, peripheral_select_n, local_addr_strobe_n, claim_active}), 24'he);
    $display("test reset done");
    t_dir();
    t_sel();
    t_claim();
    strobe_case(1'b0, 1'b1, mr);
    strobe_case(1'b1, 1'b1, mw);
    strobe_case(1'b0, 1'b0, mw);
    $display("test strobe done");
    t_strap(1'b1);
    t_strap(1'b0);
    finish_test();
  end
  initial begin
    #1500000;
    failures++;
    finish_test();
  end
endmodule : tb
